// ### rtl/idsplit_mapper.sv
// instruction/data split mapper with apb registers and boot write inhibit
// assumes cpu presents a registered access request each cycle
//
// Contract
// - control bits 7:6 ignore writes and read as zero
// - bit5 clear: inversions apply to fetches and data alike
// - bit5 set: inversions apply only to data accesses
// - bit4 set holds battery sram select asserted
// - bit3 inverts a19 for data-window accesses before bank choice
// - bit2 inverts a16 for data-window accesses
// - bit1 inverts a19 for root accesses before bank choice
// - bit0 inverts a16 for root accesses
// - root and data window split into separate i and d spaces
// - bank0 control resets with boot write strobe inhibited
// - after reset fetching starts at address zero of boot memory
// - opcode 0xff is decoded as the restart instruction
// - restart goes to fixed vector; default stack at bottom
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module idsplit_mapper
  import idsplit_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_req,
  input wire logic cpu_fetch,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_logical,
  input wire logic [19:0] cpu_phys,
  input wire logic [7:0] fetch_opcode,
  output logic [19:0] mem_addr,
  output logic boot_memory_select_n,
  output logic boot_output_strobe_n,
  output logic boot_write_strobe_n,
  output logic battery_sram_select_n,
  output logic restart_take,
  output logic [15:0] restart_target,
  output logic [15:0] restart_stack
);
  import idsplit_pkg::*;
  // ***************************************************************
  // registers
  // ***************************************************************
  logic [5:0] split_ctrl_q;
  logic [7:0] bank0_ctrl_q;
  logic [15:0] stack_q;
  logic boot_q;
  logic fetch_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] off;
  assign off = paddr[7:0];
  assign mapped = (paddr[31:8] == 24'h000000) &&
                  (off == split_ctrl_addr || off == bank0_ctrl_addr || off == status_addr);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && !penable && !pwrite;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      split_ctrl_q <= split_ctrl_reset[5:0];
    else if (wr_en && off == split_ctrl_addr)
      split_ctrl_q <= pwdata[5:0] & split_ctrl_wmask;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      bank0_ctrl_q <= bank0_ctrl_reset;
    else if (wr_en && off == bank0_ctrl_addr)
      bank0_ctrl_q <= pwdata[7:0];
  end
  // ***************************************************************
  // apb slave: one wait-free access phase, setup data registered
  // ***************************************************************
  // ready answers every setup, so a master never stalls on this slave
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !mapped;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (off)
        split_ctrl_addr:
        begin
          prdata <= {26'h0, split_ctrl_q};
        end
        bank0_ctrl_addr:
        begin
          prdata <= {24'h0, bank0_ctrl_q};
        end
        status_addr:
        begin
          prdata <= {30'h0, restart_take, boot_q};
        end
        default:
        begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end
  // ***************************************************************
  // segment classification and inversion
  // ***************************************************************
  function automatic seg_t classify(input logic [15:0] la);
    if (la < root_top_reset)
      return seg_root;
    else if (la < dseg_top_reset)
      return seg_data;
    else
      return seg_other;
  endfunction
  seg_t seg;
  logic [19:0] phys_src;
  logic [19:0] inv_addr;
  assign seg = classify(cpu_logical);
  // first fetch after reset forced to boot address zero
  assign phys_src = boot_q ? boot_fetch_addr : cpu_phys;
  // the boot fetch bypasses every inversion
  seg_t seg_eff;
  assign seg_eff = boot_q ? seg_other : seg;
  addr_invert u_inv (
    .addr_in(phys_src),
    .seg(seg_eff),
    .is_fetch(cpu_fetch),
    .ctrl(split_ctrl_q),
    .addr_out(inv_addr)
  );
  // bank choice uses the inverted a19, so it lands after the inversion
  function automatic logic bank0_sel(input logic [19:0] pa);
    return !pa[addr_a19_bit];
  endfunction
  logic bank0_hit;
  assign bank0_hit = bank0_sel(inv_addr);
  always_ff @(posedge clk)
  begin
    if (!nrst)
      boot_q <= 1'b1;
    else if (cpu_req && cpu_fetch)
      boot_q <= 1'b0;
  end
  // ***************************************************************
  // memory selects and strobes
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mem_addr <= boot_fetch_addr;
    else
      mem_addr <= inv_addr;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      boot_memory_select_n <= 1'b1;
    else
      boot_memory_select_n <= !(cpu_req && bank0_hit);
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      boot_output_strobe_n <= 1'b1;
    else
      boot_output_strobe_n <= !(cpu_req && bank0_hit && !cpu_write);
  end
  // inhibit bit keeps boot flash safe from stray writes
  always_ff @(posedge clk)
  begin
    if (!nrst)
      boot_write_strobe_n <= 1'b1;
    else
      boot_write_strobe_n <= !(cpu_req && bank0_hit && cpu_write &&
                               !bank0_ctrl_q[bank0_wr_inhibit_bit]);
  end
  // forcing the select is only safe when no other memory shares its strobes
  always_ff @(posedge clk)
  begin
    if (!nrst)
      battery_sram_select_n <= 1'b1;
    else
      battery_sram_select_n <= !(split_ctrl_q[force_sram_bit] ||
                                 (cpu_req && !bank0_hit));
  end
  // ***************************************************************
  // restart decode
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
      fetch_q <= 1'b0;
    else
      fetch_q <= cpu_req && cpu_fetch;
  end
  // the opcode comes back a cycle after the fetch address goes out
  always_ff @(posedge clk)
  begin
    if (!nrst)
      restart_take <= 1'b0;
    else
      restart_take <= fetch_q && fetch_opcode == restart_opcode;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      restart_target <= restart_vector;
    else
      restart_target <= restart_vector;
  end
  // the stack sits in flash at stack_default; no register write can move it
  always_ff @(posedge clk)
  begin
    if (!nrst)
      stack_q <= stack_default;
    else
      stack_q <= stack_q;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      restart_stack <= stack_default;
    else
      restart_stack <= stack_q;
  end
  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ctrl_top_zero_a: assert property (
    psel && !penable && !pwrite && off == split_ctrl_addr
    |=> prdata[7:6] == 2'b00)
    else $error("split control top bits not zero");
  ctrl_read_zero_a: assert property (
    psel && penable && pready && !pwrite && off == split_ctrl_addr
    |-> prdata[7:6] == 2'b00)
    else $error("split control read shows top bits");
  fetch_pass_a: assert property (
    split_ctrl_q[split_data_only_bit] && cpu_fetch && !boot_q
    |-> inv_addr == cpu_phys)
    else $error("fetch inverted in split mode");
  shared_inv_a: assert property (
    !split_ctrl_q[split_data_only_bit] && !boot_q && seg == seg_root && split_ctrl_q[root_a16_bit]
    |-> inv_addr[addr_a16_bit] != cpu_phys[addr_a16_bit])
    else $error("root a16 not inverted");
  shared_fetch_a: assert property (
    !split_ctrl_q[split_data_only_bit] && !boot_q && cpu_fetch && seg == seg_data
    && split_ctrl_q[dseg_a19_bit] |-> inv_addr[addr_a19_bit] != cpu_phys[addr_a19_bit])
    else $error("shared fetch a19 not inverted");
  force_sram_a: assert property (
    split_ctrl_q[force_sram_bit]
    |=> !battery_sram_select_n)
    else $error("battery select not forced");
  force_off_a: assert property (
    !split_ctrl_q[force_sram_bit] && !cpu_req
    |=> battery_sram_select_n)
    else $error("battery select active while idle");
  dseg_a19_a: assert property (
    !boot_q && seg == seg_data && !cpu_fetch && split_ctrl_q[dseg_a19_bit]
    |-> inv_addr[addr_a19_bit] != cpu_phys[addr_a19_bit])
    else $error("data window a19 not inverted");
  dseg_a16_a: assert property (
    !boot_q && seg == seg_data && !split_ctrl_q[dseg_a16_bit]
    |-> inv_addr[addr_a16_bit] == cpu_phys[addr_a16_bit])
    else $error("data window a16 changed");
  root_a19_a: assert property (
    !boot_q && seg == seg_root && !cpu_fetch && split_ctrl_q[root_a19_bit]
    |-> inv_addr[addr_a19_bit] != cpu_phys[addr_a19_bit])
    else $error("root a19 not inverted");
  root_a16_a: assert property (
    !boot_q && seg == seg_root && !cpu_fetch && split_ctrl_q[root_a16_bit]
    |-> inv_addr[addr_a16_bit] != cpu_phys[addr_a16_bit])
    else $error("root a16 not inverted for data");
  split_space_a: assert property (
    split_ctrl_q[split_data_only_bit] && !boot_q && cpu_fetch && seg != seg_other
    |-> inv_addr == cpu_phys)
    else $error("instruction space moved by split");
  write_inhibit_a: assert property (
    bank0_ctrl_q[bank0_wr_inhibit_bit]
    |=> boot_write_strobe_n)
    else $error("boot write while inhibited");
  bank0_reset_a: assert property (
    disable iff (1'b0) !nrst
    |=> bank0_ctrl_q == bank0_ctrl_reset)
    else $error("bank0 control not at reset value");
  write_select_a: assert property (
    !bank0_ctrl_q[bank0_wr_inhibit_bit] && cpu_req && cpu_write && bank0_sel(inv_addr)
    |=> !boot_write_strobe_n)
    else $error("enabled boot write missing");
  boot_fetch_a: assert property (
    boot_q && cpu_req && cpu_fetch
    |=> mem_addr == boot_fetch_addr && !boot_memory_select_n)
    else $error("first fetch not at boot address");
  restart_a: assert property (
    fetch_q && fetch_opcode == restart_opcode
    |=> restart_take && restart_target == restart_vector)
    else $error("restart missed");
  restart_only_a: assert property (
    !fetch_q
    |=> !restart_take)
    else $error("restart without fetch");
  restart_vec_a: assert property (
    restart_take
    |-> restart_target == restart_vector && restart_stack == stack_default)
    else $error("restart vector or stack wrong");
  other_pass_a: assert property (
    seg == seg_other
    |-> inv_addr == phys_src)
    else $error("other segment modified");
  mem_addr_reg_a: assert property (
    cpu_req
    |=> mem_addr == $past(inv_addr))
    else $error("memory address not from this cycle");
  // ***************************************************************
  // coverage
  // ***************************************************************
  split_cov: cover property (split_ctrl_q[split_data_only_bit] && cpu_req && !cpu_fetch);
  force_cov: cover property (split_ctrl_q[force_sram_bit]);
  restart_cov: cover property (restart_take);
  boot_cov: cover property (boot_q && cpu_req && cpu_fetch);
  inhibit_cov: cover property (bank0_ctrl_q[bank0_wr_inhibit_bit] && cpu_req && cpu_write);
endmodule // idsplit_mapper
`default_nettype wire

// ### rtl/idsplit_pkg.sv
// package for the instruction/data split address mapper
// assumes a 32-bit apb register bus and one 250 mhz clock
package idsplit_pkg;
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] split_ctrl_addr = 8'h10;
  localparam logic [7:0] bank0_ctrl_addr = 8'h14;
  localparam logic [7:0] status_addr = 8'h18;
  localparam logic [7:0] split_ctrl_reset = 8'h00;
  localparam logic [7:0] bank0_ctrl_reset = 8'h08;
  localparam logic [5:0] split_ctrl_wmask = 6'h3F;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int split_data_only_bit = 5;
  localparam int force_sram_bit = 4;
  localparam int dseg_a19_bit = 3;
  localparam int dseg_a16_bit = 2;
  localparam int root_a19_bit = 1;
  localparam int root_a16_bit = 0;
  localparam int bank0_wr_inhibit_bit = 3;
  localparam int addr_a16_bit = 16;
  localparam int addr_a19_bit = 19;
  // ***************************************************************
  // segment boundaries (logical) and restart figures
  // ***************************************************************
  localparam logic [15:0] root_top_reset = 16'h6000;
  localparam logic [15:0] dseg_top_reset = 16'hD000;
  localparam logic [7:0] restart_opcode = 8'hFF;
  localparam logic [15:0] restart_vector = 16'h0070;
  localparam logic [15:0] stack_default = 16'h0000;
  localparam logic [19:0] boot_fetch_addr = 20'h00000;
  typedef enum logic [2:0] {
    seg_root = 3'b001,
    seg_data = 3'b010,
    seg_other = 3'b100
  } seg_t;
endpackage

// ### rtl/addr_invert.sv
// combinational inversion of physical address bits 16 and 19
// assumes segment class is already decided by the caller
`timescale 1ns/1ps
`default_nettype none
module addr_invert
  import idsplit_pkg::*;
(
  input wire logic [19:0] addr_in,
  input wire idsplit_pkg::seg_t seg,
  input wire logic is_fetch,
  input wire logic [5:0] ctrl,
  output logic [19:0] addr_out
);
  logic qual;
  logic inv16;
  logic inv19;
  always_comb
  begin
    // data-only mode leaves fetches untouched
    qual = !(ctrl[split_data_only_bit] && is_fetch);
    inv16 = 1'b0;
    inv19 = 1'b0;
    case (seg)
      seg_root:
      begin
        inv16 = qual && ctrl[root_a16_bit];
        inv19 = qual && ctrl[root_a19_bit];
      end
      seg_data:
      begin
        inv16 = qual && ctrl[dseg_a16_bit];
        inv19 = qual && ctrl[dseg_a19_bit];
      end
      default:
      begin
        inv16 = 1'b0;
        inv19 = 1'b0;
      end
    endcase
    addr_out = addr_in;
    addr_out[addr_a16_bit] = addr_in[addr_a16_bit] ^ inv16;
    addr_out[addr_a19_bit] = addr_in[addr_a19_bit] ^ inv19;
  end
endmodule // addr_invert
`default_nettype wire

// ### rtl/unused_placeholder_none.sv
// intentionally empty helper file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb/boot_flash_model.sv
// model of the erased boot flash behind the boot memory select
// assumes the mapper's registered address and active-low strobes
`timescale 1ns/1ps
`default_nettype none
module boot_flash_model
(
  input wire logic clk,
  input wire logic [19:0] mem_addr,
  input wire logic boot_memory_select_n,
  input wire logic boot_output_strobe_n,
  output logic [7:0] fetch_opcode
);
  // ***************************************************************
  // read path
  // ***************************************************************
  // released bus drifts each cycle so no stale byte is seen; never all ones
  logic [7:0] drift_q;
  initial drift_q = 8'h3C;
  always @(posedge clk)
    drift_q <= drift_q ^ 8'h5A;
  // word zero is erased, the rest holds a plain opcode
  assign fetch_opcode = (!boot_memory_select_n && !boot_output_strobe_n) ?
    ((mem_addr == 20'h00000) ? 8'hFF : 8'h00) : drift_q;
endmodule // boot_flash_model
`default_nettype wire

// ### tb/instr_data_split_address_mapper_tb_top.sv
// self-checking bench for the split mapper: apb tasks and cpu accesses
// assumes the erased flash model on the fetch byte and a 250 mhz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t: got %0h expected %0h", $time, a, e); end end
module instr_data_split_address_mapper_tb_top;
  import idsplit_pkg::*;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic pready, pslverr, er, cpu_req = 1'b0, cpu_fetch = 1'b0, cpu_write = 1'b0;
  logic [15:0] cpu_logical = 16'h0, restart_target, restart_stack, lg;
  logic [19:0] cpu_phys = 20'h0, mem_addr, e;
  logic [7:0] fetch_opcode;
  logic [5:0] c;
  logic boot_memory_select_n, boot_output_strobe_n, boot_write_strobe_n;
  logic battery_sram_select_n, restart_take;
  int fail_count = 0, total_checks = 0, restart_cnt = 0;
  always #2 clk = ~clk;
  always @(posedge clk)
    if (restart_take === 1'b1) restart_cnt++;
  idsplit_mapper dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_req(cpu_req), .cpu_fetch(cpu_fetch), .cpu_write(cpu_write),
    .cpu_logical(cpu_logical), .cpu_phys(cpu_phys), .fetch_opcode(fetch_opcode),
    .mem_addr(mem_addr), .boot_memory_select_n(boot_memory_select_n),
    .boot_output_strobe_n(boot_output_strobe_n), .boot_write_strobe_n(boot_write_strobe_n),
    .battery_sram_select_n(battery_sram_select_n), .restart_take(restart_take),
    .restart_target(restart_target), .restart_stack(restart_stack));
  boot_flash_model flash (.clk(clk), .mem_addr(mem_addr),
    .boot_memory_select_n(boot_memory_select_n),
    .boot_output_strobe_n(boot_output_strobe_n), .fetch_opcode(fetch_opcode));
  // ***************************************************************
  // tasks
  // ***************************************************************
  function automatic logic [19:0] exp_addr(logic [5:0] k, logic f, logic [15:0] lg,
    logic [19:0] ph);
    logic [19:0] a;
    a = ph;
    if (!(k[5] && f) && lg < root_top_reset)
    begin
      a[16] = a[16] ^ k[0];
      a[19] = a[19] ^ k[1];
    end
    else if (!(k[5] && f) && lg < dseg_top_reset)
    begin
      a[16] = a[16] ^ k[2];
      a[19] = a[19] ^ k[3];
    end
    return a;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, ad};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    er = pslverr;
    `CHK(pready, 1'b1)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] x, input logic xe);
    apb(1'b0, ad, 32'h0);
    `CHK(r, x)
    `CHK(er, xe)
  endtask
  // one cpu request; the mapped address shows on the same edge that takes it
  task automatic cpu(input logic f, input logic w, input logic [15:0] lg,
    input logic [19:0] ph, input logic [19:0] x);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_fetch <= f;
    cpu_write <= w;
    cpu_logical <= lg;
    cpu_phys <= ph;
    @(posedge clk);
    cpu_req <= 1'b0;
    #1;
    `CHK(mem_addr, x)
    `CHK(boot_memory_select_n, x[19])
    `CHK(boot_output_strobe_n, x[19] | w)
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ***************************************************************
  // tests
  // ***************************************************************
  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    cpu(1'b1, 1'b0, 16'hE000, 20'h8ABCD, 20'h00000);
    repeat (4) @(posedge clk);
    `CHK(restart_cnt, 1)
    `CHK(restart_target, 16'h0070)
    `CHK(restart_stack, 16'h0000)
    rd_chk(8'h10, 32'h0, 1'b0);
    rd_chk(8'h14, 32'h08, 1'b0);
    rd_chk(8'h18, 32'h0, 1'b0);
    rd_chk(8'h1C, 32'h0, 1'b1);
    cpu(1'b0, 1'b1, 16'h7000, 20'h01000, 20'h01000);
    `CHK(boot_write_strobe_n, 1'b1)
    apb(1'b1, 8'h14, 32'h0);
    cpu(1'b0, 1'b1, 16'h7000, 20'h01000, 20'h01000);
    `CHK(boot_write_strobe_n, 1'b0)
    apb(1'b1, 8'h10, 32'hFF);
    rd_chk(8'h10, 32'h3F, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    `CHK(battery_sram_select_n, 1'b0)
    // sweep every inversion enable with and without the split
    for (int i = 0; i < 32; i++)
    begin
      c = {i[4], 1'b0, i[3:0]};
      apb(1'b1, 8'h10, {26'h0, c});
      for (int s = 0; s < 6; s++)
      begin
        lg = (s / 2 == 0) ? 16'h1000 : ((s / 2 == 1) ? 16'h9000 : 16'hE000);
        e = exp_addr(c, s[0], lg, 20'h2C0DE);
        cpu(s[0], 1'b0, lg, 20'h2C0DE, e);
        `CHK(battery_sram_select_n, ~e[19])
      end
    end
    `CHK(restart_cnt, 1)
    tally_and_finish;
  end
endmodule // instr_data_split_address_mapper_tb_top
`default_nettype wire
